//--- rtl/adc_params.svh
// constants of the serial port and conversion sequencer
// assumes a 25 MHz system clock and host pins arriving asynchronously
//
// Function
// RULE1: result output changes on shift-clock falling edges
// RULE2: result output high impedance while select high
// RULE3: command input sampled on shift-clock rising edges
// RULE4: command input ignored unless select is low
// RULE5: internal mode strobe low during conversion
// RULE6: external mode strobe high two periods before MSB
// RULE7: external mode strobe floats while select high
// RULE8: host keeps external shift clock near 50% duty
// RULE9: power-down pin: float on, low off, high ref-off
// RULE10: two-cycle acquisition ends after last command bit
// RULE11: single-ended uses channel versus common ground
// RULE12: differential uses only adjacent channel pairs
// RULE13: conversion switches hold capacitor, then 8-bit SAR
// RULE14: first one after select low is start
// RULE15: track after sixth bit, hold after eighth
// RULE16: command byte field order, start bit first
// RULE17: result shifted out MSB first per falling edge
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// ****************************************************************
// command byte layout
// ****************************************************************
`define CMD_BITS           4'h8
`define CMD_START_POS      7
`define CMD_CHANNEL_SELECT_BIT_2_POS       6
`define CMD_CHANNEL_SELECT_BIT_1_POS       5
`define CMD_CHANNEL_SELECT_BIT_0_POS       4
`define CMD_POLARITY_POS   3
`define CMD_PAIRING_POS    2
`define CMD_PM1_POS        1
`define CMD_PM0_POS        0
`define TRACK_AFTER_BIT    4'h6
`define HOLD_AFTER_BIT     4'h8
`define PM_EXTERNAL_CLOCK  2'h3

// ****************************************************************
// conversion timing
// ****************************************************************
`define RESULT_BITS        4'h8
`define STROBE_RISE_FALL   5'h07
`define CLK_PERIOD_NS      40
`define INT_STEP_NS        1000
`define INT_STEP_CYCLES    ((`INT_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SAR_MSB_TRIAL      8'h80

`endif

//--- rtl/adc_pkg.sv
// types shared by the sequencer and the approximation engine
// assumes adc_params.svh holds every number
package adc_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'h0,
		ST_CMD  = 2'h1,
		ST_CONV = 2'h2,
		ST_OUT  = 2'h3
	} seq_state_t;

	typedef logic [7:0] byte_t;

endpackage : adc_pkg

//--- rtl/adc_serial_port_sequencer.sv
// serial command/result port and conversion sequencer of the adc
// assumes host pins are asynchronous and the shift clock is much
// slower than clk, so its edges are found by oversampling
`timescale 1ns/1ps
`default_nettype none
`include "adc_params.svh"

module adc_serial_port_sequencer
(
	input  wire logic        clk,                   // 25 MHz clock
	input  wire logic        rst,                   // async, high
	input  wire logic        shift_clock,           // host shift clock
	input  wire logic        chip_select_n,         // host select, low
	input  wire logic        command_in,            // host command bit
	input  wire logic        comp_hi,               // comparator level
	input  wire logic        power_down_sense_low,  // pin driven low
	input  wire logic        power_down_sense_high, // pin driven high
	output logic             result_out,            // serial result
	output logic             result_out_oe,         // result driven
	output logic             conversion_strobe,     // strobe level
	output logic             conversion_strobe_oe,  // strobe driven
	output logic             track_switch,          // t/h switch closed
	output logic             hold_capacitor_to_neg, // cap on negative
	output logic [7:0]       pos_channel,           // one-hot plus input
	output logic [7:0]       neg_channel,           // one-hot return, zero when common
	output logic             neg_to_common,         // return is common
	output logic             bipolar_mode,          // polarity select
	output logic [1:0]       power_mode,            // power mode bits
	output adc_pkg::byte_t   dac_code,              // capacitor dac code
	output logic             shutdown_all,          // full shutdown
	output logic             shutdown_reference     // reference off
);

	// ****************************************************************
	// channel decode
	// ****************************************************************
	// channel index is {channel_select_bit_1, channel_select_bit_0, channel_select_bit_2}; differential return is
	// the neighbour of the same pair
	function automatic logic [7:0] chan_onehot
	(
		input logic channel_select_bit_2,
		input logic channel_select_bit_1,
		input logic channel_select_bit_0
	);
		logic [2:0] idx;
		idx = {channel_select_bit_1, channel_select_bit_0, channel_select_bit_2};
		chan_onehot = 8'h01 << idx;
	endfunction : chan_onehot

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	logic [1:0] sclk_sync;
	logic [1:0] cs_sync;
	logic [1:0] din_sync;
	logic [1:0] pdl_sync;
	logic [1:0] pdh_sync;
	logic       sclk_last;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_sync <= 2'h0;
			cs_sync   <= 2'h3;
			din_sync  <= 2'h0;
			pdl_sync  <= 2'h0;
			pdh_sync  <= 2'h0;
			sclk_last <= 1'b0;
		end
		else
		begin
			sclk_sync <= {sclk_sync[0], shift_clock};
			cs_sync   <= {cs_sync[0], chip_select_n};
			din_sync  <= {din_sync[0], command_in};
			pdl_sync  <= {pdl_sync[0], power_down_sense_low};
			pdh_sync  <= {pdh_sync[0], power_down_sense_high};
			sclk_last <= sclk_sync[1];
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_high;
	logic din_bit;

	assign sclk_rise = sclk_sync[1] & ~sclk_last;
	assign sclk_fall = ~sclk_sync[1] & sclk_last;
	assign cs_high   = cs_sync[1];
	assign din_bit   = din_sync[1];

	// ****************************************************************
	// sequencer state
	// ****************************************************************
	adc_pkg::seq_state_t state;
	adc_pkg::seq_state_t next_state;
	adc_pkg::byte_t      cmd;
	adc_pkg::byte_t      next_cmd;
	adc_pkg::byte_t      shift;
	adc_pkg::byte_t      next_shift;
	logic [3:0]          bit_cnt;
	logic [3:0]          next_bit_cnt;
	logic [3:0]          out_cnt;
	logic [3:0]          next_out_cnt;
	logic [4:0]          fall_cnt;
	logic [4:0]          next_fall_cnt;
	logic [15:0]         pace_cnt;
	logic [15:0]         next_pace_cnt;
	logic                ext_mode;
	logic                next_ext_mode;
	logic                next_result_out;
	logic                next_result_out_oe;
	logic                next_strobe;
	logic                next_strobe_oe;
	logic                next_track;
	logic                next_hold_neg;
	logic [7:0]          next_pos;
	logic [7:0]          next_neg;
	logic                next_neg_com;
	logic                next_bipolar;
	logic [1:0]          next_power_mode;
	logic                next_shutdown_all;
	logic                next_shutdown_ref;
	logic                sar_start;
	logic                sar_step;
	logic                sar_busy;
	logic                sar_done;
	adc_pkg::byte_t      sar_result;

	sar_engine u_sar
	(
		.clk      (clk),
		.rst      (rst),
		.start    (sar_start),
		.step     (sar_step),
		.comp_hi  (comp_hi),
		.busy     (sar_busy),
		.done     (sar_done),
		.dac_code (dac_code),
		.result   (sar_result)
	);

	always_comb
	begin
		next_state         = state;
		next_cmd           = cmd;
		next_shift         = shift;
		next_bit_cnt       = bit_cnt;
		next_out_cnt       = out_cnt;
		next_fall_cnt      = fall_cnt;
		next_pace_cnt      = pace_cnt;
		next_ext_mode      = ext_mode;
		next_result_out    = result_out;
		next_strobe        = conversion_strobe;
		next_track         = track_switch;
		next_hold_neg      = hold_capacitor_to_neg;
		next_pos           = pos_channel;
		next_neg           = neg_channel;
		next_neg_com       = neg_to_common;
		next_bipolar       = bipolar_mode;
		next_power_mode    = power_mode;
		sar_start          = 1'b0;
		sar_step           = 1'b0;

		// open pin reads neither sense level [RULE9]
		next_shutdown_all  = pdl_sync[1] & ~pdh_sync[1];
		next_shutdown_ref  = pdh_sync[1] & ~pdl_sync[1];

		next_result_out_oe = ~cs_high;                         // [RULE2]
		next_strobe_oe     = ~(ext_mode & cs_high);            // [RULE7]

		case (state)
			adc_pkg::ST_IDLE:
			begin
				next_bit_cnt = 4'h0;
				// external mode strobe rests low outside its pulse
				next_strobe  = ~ext_mode;                      // [RULE6]
				// leading zeros are skipped until the start bit [RULE14]
				if (!cs_high && sclk_rise && din_bit)          // [RULE3] [RULE4]
				begin
					next_cmd     = 8'h01;
					next_bit_cnt = 4'h1;
					next_state   = adc_pkg::ST_CMD;
				end
			end
			adc_pkg::ST_CMD:
			begin
				if (cs_high)
				begin
					next_track = 1'b0;
					next_state = adc_pkg::ST_IDLE;
				end
				else if (sclk_rise && bit_cnt < `CMD_BITS)     // [RULE3]
				begin
					next_cmd     = {cmd[6:0], din_bit};
					next_bit_cnt = bit_cnt + 4'h1;
				end
				else if (sclk_fall && bit_cnt == `TRACK_AFTER_BIT)
				begin
					// after six bits cmd[5:0] holds start..pairing [RULE16]
					next_track    = 1'b1;                      // [RULE15] [RULE10]
					next_bit_cnt  = bit_cnt + 4'h0;
					next_bipolar  = ~cmd[0 + 1];
					next_pos      = chan_onehot(cmd[4], cmd[3], cmd[2]);
					if (cmd[0])
					begin
						next_neg     = 8'h00;                  // [RULE11]
						next_neg_com = 1'b1;
					end
					else
					begin
						next_neg     = chan_onehot(~cmd[4], cmd[3],
							cmd[2]);                           // [RULE12]
						next_neg_com = 1'b0;
					end
				end
				else if (sclk_fall && bit_cnt == `HOLD_AFTER_BIT)
				begin
					next_track      = 1'b0;                    // [RULE15] [RULE10]
					next_hold_neg   = 1'b1;                    // [RULE13]
					next_power_mode = cmd[`CMD_PM1_POS:`CMD_PM0_POS];
					next_ext_mode   = (cmd[`CMD_PM1_POS:`CMD_PM0_POS]
						== `PM_EXTERNAL_CLOCK);
					next_strobe     = 1'b0;                    // [RULE5]
					next_fall_cnt   = 5'h00;
					next_pace_cnt   = 16'h0000;
					sar_start       = 1'b1;
					next_state      = adc_pkg::ST_CONV;
				end
			end
			adc_pkg::ST_CONV:
			begin
				if (cs_high && ext_mode)
				begin
					// no shift clock can pace the rest of it
					next_hold_neg = 1'b0;
					next_state    = adc_pkg::ST_IDLE;
				end
				else if (sar_done)
				begin
					next_hold_neg = 1'b0;
					next_shift    = sar_result;
					next_out_cnt  = 4'h0;
					next_strobe   = ext_mode ? conversion_strobe : 1'b1; // [RULE5]
					next_state    = adc_pkg::ST_OUT;
				end
				else if (ext_mode)
				begin
					// host clock paces each approximation step [RULE8]
					if (sclk_fall)
					begin
						next_fall_cnt = fall_cnt + 5'h01;
						sar_step      = sar_busy;
						if (next_fall_cnt == `STROBE_RISE_FALL)
							next_strobe = 1'b1;                // [RULE6]
					end
				end
				else
				begin
					if (pace_cnt == 16'(`INT_STEP_CYCLES - 1))
					begin
						next_pace_cnt = 16'h0000;
						sar_step      = 1'b1;                  // [RULE13]
					end
					else
						next_pace_cnt = pace_cnt + 16'h0001;
				end
			end
			adc_pkg::ST_OUT:
			begin
				if (cs_high)
					next_state = adc_pkg::ST_IDLE;
				else if (sclk_fall)
				begin
					// in external mode the strobe ends as the MSB leaves
					next_strobe = 1'b1 & ~ext_mode;            // [RULE6]
					if (out_cnt < `RESULT_BITS)
					begin
						next_result_out = shift[7];            // [RULE1] [RULE17]
						next_shift      = {shift[6:0], 1'b0};
						next_out_cnt    = out_cnt + 4'h1;
					end
					else
					begin
						next_result_out = 1'b0;
						next_state      = adc_pkg::ST_IDLE;
					end
				end
			end
			default:
				next_state = adc_pkg::ST_IDLE;
		endcase

		if (ext_mode && state == adc_pkg::ST_OUT)
			next_strobe = sclk_fall ? 1'b0 : next_strobe;

		// complete shutdown stops any sequence in progress
		if (next_shutdown_all)
		begin
			next_state    = adc_pkg::ST_IDLE;
			next_track    = 1'b0;
			next_hold_neg = 1'b0;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state                 <= adc_pkg::ST_IDLE;
			cmd                   <= 8'h00;
			shift                 <= 8'h00;
			bit_cnt               <= 4'h0;
			out_cnt               <= 4'h0;
			fall_cnt              <= 5'h00;
			pace_cnt              <= 16'h0000;
			ext_mode              <= 1'b0;
			result_out            <= 1'b0;
			result_out_oe         <= 1'b0;
			conversion_strobe     <= 1'b1;
			conversion_strobe_oe  <= 1'b1;
			track_switch          <= 1'b0;
			hold_capacitor_to_neg <= 1'b0;
			pos_channel           <= 8'h01;
			neg_channel           <= 8'h00;
			neg_to_common         <= 1'b1;
			bipolar_mode          <= 1'b0;
			power_mode            <= 2'h0;
			shutdown_all          <= 1'b0;
			shutdown_reference    <= 1'b0;
		end
		else
		begin
			state                 <= next_state;
			cmd                   <= next_cmd;
			shift                 <= next_shift;
			bit_cnt               <= next_bit_cnt;
			out_cnt               <= next_out_cnt;
			fall_cnt              <= next_fall_cnt;
			pace_cnt              <= next_pace_cnt;
			ext_mode              <= next_ext_mode;
			result_out            <= next_result_out;
			result_out_oe         <= next_result_out_oe;
			conversion_strobe     <= next_strobe;
			conversion_strobe_oe  <= next_strobe_oe;
			track_switch          <= next_track;
			hold_capacitor_to_neg <= next_hold_neg;
			pos_channel           <= next_pos;
			neg_channel           <= next_neg;
			neg_to_common         <= next_neg_com;
			bipolar_mode          <= next_bipolar;
			power_mode            <= next_power_mode;
			shutdown_all          <= next_shutdown_all;
			shutdown_reference    <= next_shutdown_ref;
		end
	end

endmodule : adc_serial_port_sequencer

`default_nettype wire

//--- rtl/sar_engine.sv
// eight-step successive approximation register
// assumes comparator level is valid when a step pulse arrives
`timescale 1ns/1ps
`default_nettype none
`include "adc_params.svh"

module sar_engine
(
	input  wire logic         clk,      // system clock
	input  wire logic         rst,      // async reset, active high
	input  wire logic         start,    // begin a new conversion
	input  wire logic         step,     // resolve one bit
	input  wire logic         comp_hi,  // sampled input above dac code
	output logic              busy,     // conversion in progress
	output logic              done,     // one-cycle end of conversion
	output adc_pkg::byte_t    dac_code, // trial code to capacitor dac
	output adc_pkg::byte_t    result    // finished code
);

	adc_pkg::byte_t next_dac_code;
	adc_pkg::byte_t next_result;
	adc_pkg::byte_t trial;
	adc_pkg::byte_t next_trial;
	logic           next_busy;
	logic           next_done;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		next_dac_code = dac_code;
		next_result   = result;
		next_trial    = trial;
		next_busy     = busy;
		next_done     = 1'b0;
		if (start)
		begin
			next_trial    = `SAR_MSB_TRIAL;
			next_dac_code = `SAR_MSB_TRIAL;
			next_busy     = 1'b1;
		end
		else if (step && busy)
		begin
			// keep the trial bit only if input still above code [RULE13]
			next_dac_code = comp_hi ? dac_code : (dac_code & ~trial);
			next_trial    = trial >> 1;
			next_dac_code = next_dac_code | next_trial;
			if (trial == 8'h01)
			begin
				next_busy   = 1'b0;
				next_done   = 1'b1;
				next_result = comp_hi ? dac_code : (dac_code & ~trial);
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dac_code <= 8'h00;
			result   <= 8'h00;
			trial    <= 8'h00;
			busy     <= 1'b0;
			done     <= 1'b0;
		end
		else
		begin
			dac_code <= next_dac_code;
			result   <= next_result;
			trial    <= next_trial;
			busy     <= next_busy;
			done     <= next_done;
		end
	end

endmodule : sar_engine

`default_nettype wire

//--- tb/adc_checker_assertions.sv
// checker of the sequencer's serial port and conversion outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module adc_checker_assertions
(
	input wire logic       clk, // clock
	input wire logic       rst, // reset
	input wire logic       shift_clock, // shift clock
	input wire logic       chip_select_n, // select
	input wire logic       power_down_sense_low, // pin low
	input wire logic       power_down_sense_high, // pin high
	input wire logic       result_out, // result bit
	input wire logic       result_out_oe, // result oe
	input wire logic       conversion_strobe, // strobe
	input wire logic       conversion_strobe_oe, // strobe oe
	input wire logic       track_switch, // t/h closed
	input wire logic       hold_capacitor_to_neg, // cap on neg
	input wire logic [7:0] pos_channel, // plus input
	input wire logic [7:0] neg_channel, // return input
	input wire logic       neg_to_common, // return common
	input wire logic [1:0] power_mode, // power bits
	input wire logic       shutdown_all, // full off
	input wire logic       shutdown_reference // ref off
);
	logic       sclk_d;
	logic [5:0] fall_hist;

	// ********
	// recent shift clock falls, wide enough for the pin pipeline
	// ********
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sclk_d    <= 1'b0;
			fall_hist <= 6'h00;
		end
		else
		begin
			sclk_d    <= shift_clock;
			fall_hist <= {fall_hist[4:0], sclk_d & ~shift_clock};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_acquiring;
		track_switch [*8];
	endsequence
	sequence s_held;
		!track_switch && hold_capacitor_to_neg;
	endsequence

	property p_result_on_fall;
		!chip_select_n && $changed(result_out) |-> |fall_hist;
	endproperty
	a_result_on_fall: assert property (p_result_on_fall)
		else $error("result moved without a shift clock fall");
	property p_result_float;
		chip_select_n [*5] |-> !result_out_oe;
	endproperty
	a_result_float: assert property (p_result_float)
		else $error("result driven while deselected");
	property p_strobe_float;
		(chip_select_n && power_mode == 2'h3) [*5] |-> !conversion_strobe_oe;
	endproperty
	a_strobe_float: assert property (p_strobe_float)
		else $error("strobe driven while deselected");
	property p_no_shift;
		chip_select_n [*6] |-> $stable(pos_channel) && $stable(power_mode);
	endproperty
	a_no_shift: assert property (p_no_shift)
		else $error("command taken while deselected");
	property p_acquire;
		$rose(track_switch) |-> s_acquiring ##1 s_acquiring ##[1:2] s_held;
	endproperty
	a_acquire: assert property (p_acquire)
		else $error("acquisition not two shift periods");
	property p_hold_after_track;
		$rose(hold_capacitor_to_neg) |-> $past(track_switch);
	endproperty
	a_hold_after_track: assert property (p_hold_after_track)
		else $error("hold without prior tracking");
	property p_int_strobe;
		power_mode != 2'h3 && $rose(hold_capacitor_to_neg) |-> ##[0:2]
			!conversion_strobe ##100 !conversion_strobe
			##[40:160] conversion_strobe;
	endproperty
	a_int_strobe: assert property (p_int_strobe)
		else $error("internal strobe low span wrong");
	property p_routing;
		hold_capacitor_to_neg |-> $onehot(pos_channel) && (neg_to_common ?
			neg_channel == 8'h00 : neg_channel == {pos_channel[6],
			pos_channel[7], pos_channel[4], pos_channel[5],
			pos_channel[2], pos_channel[3], pos_channel[0], pos_channel[1]});
	endproperty
	a_routing: assert property (p_routing)
		else $error("input routing wrong");
	property p_power_off;
		(power_down_sense_low && !power_down_sense_high) [*5] |-> shutdown_all;
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("pin low without shutdown");
	property p_power_ref;
		(power_down_sense_high && !power_down_sense_low) [*5]
			|-> shutdown_reference && !shutdown_all;
	endproperty
	a_power_ref: assert property (p_power_ref)
		else $error("pin high without reference off");
	property p_power_on;
		(!power_down_sense_high && !power_down_sense_low) [*5]
			|-> !shutdown_reference && !shutdown_all;
	endproperty
	a_power_on: assert property (p_power_on)
		else $error("floating pin not operational");
endmodule : adc_checker_assertions

bind adc_serial_port_sequencer adc_checker_assertions i_adc_checker_assertions
(
	.clk, .rst, .shift_clock, .chip_select_n, .power_down_sense_low,
	.power_down_sense_high, .result_out, .result_out_oe,
	.conversion_strobe, .conversion_strobe_oe, .track_switch,
	.hold_capacitor_to_neg, .pos_channel, .neg_channel, .neg_to_common,
	.power_mode, .shutdown_all, .shutdown_reference
);

`default_nettype wire

//--- tb/host_model.sv
// host serial master: select, shift clock and command bits
// assumes clk is the bench clock; pins change at its falling edge
`timescale 1ns/1ps
`default_nettype none

module host_model
(
	input  wire logic clk, // bench clock
	input  wire logic result_out, // serial result
	input  wire logic conversion_strobe, // strobe level
	input  wire logic track_switch, // t/h closed
	output logic      shift_clock, // shift clock
	output logic      chip_select_n, // select, low
	output logic      command_in // command bit
);
	logic [31:0]    track_at;
	logic [31:0]    strobe_at;
	adc_pkg::byte_t seen;
	int             rises;

	initial
	begin
		shift_clock   = 1'b0;
		chip_select_n = 1'b1;
		command_in    = 1'b0;
		rises         = 0;
	end

	// equal halves of 160 ns keep the duty cycle at half
	task pulse(input logic bit_in);
	begin
		command_in = bit_in;
		repeat (4) @(negedge clk);
		rises            = rises + 1;
		track_at[rises]  = track_switch;
		strobe_at[rises] = conversion_strobe;
		seen             = {seen[6:0], result_out};
		shift_clock      = 1'b1;
		repeat (4) @(negedge clk);
		shift_clock = 1'b0;
	end
	endtask : pulse

	task frame(input adc_pkg::byte_t cmd, input int zeros,
		output adc_pkg::byte_t res);
		int i;
	begin
		chip_select_n = 1'b0;
		repeat (4) @(negedge clk);
		for (i = 0; i < zeros; i++)
			pulse(1'b0);
		rises = 0;
		for (i = 7; i >= 0; i--)
			pulse(cmd[i]);
		if (cmd[1:0] == 2'h3)
			repeat (8) pulse(1'b0);
		else
		begin
			repeat (8) @(negedge clk);
			strobe_at[0] = conversion_strobe;
			i = 0;
			while (conversion_strobe !== 1'b1 && i < 400)
			begin
				@(negedge clk);
				i++;
			end
		end
		repeat (9) pulse(1'b0);
		res = seen;
		repeat (4) @(negedge clk);
		chip_select_n = 1'b1;
		command_in    = ~command_in;
	end
	endtask : frame

	// a frame cut short by select going high
	task abort_after(input int n);
		int i;
	begin
		chip_select_n = 1'b0;
		repeat (4) @(negedge clk);
		for (i = 0; i < n; i++)
			pulse(1'b1);
		chip_select_n = 1'b1;
		repeat (8) @(negedge clk);
	end
	endtask : abort_after
endmodule : host_model

`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the adc serial port sequencer
// assumes the host model drives the serial pins, the bench the rest
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic           clk;
	logic           rst;
	logic           shift_clock;
	logic           chip_select_n;
	logic           command_in;
	logic           comp_hi;
	logic           power_down_sense_low;
	logic           power_down_sense_high;
	logic           result_out;
	logic           result_out_oe;
	logic           conversion_strobe;
	logic           conversion_strobe_oe;
	logic           track_switch;
	logic           hold_capacitor_to_neg;
	logic [7:0]     pos_channel;
	logic [7:0]     neg_channel;
	logic           neg_to_common;
	logic           bipolar_mode;
	logic [1:0]     power_mode;
	adc_pkg::byte_t dac_code;
	logic           shutdown_all;
	logic           shutdown_reference;
	adc_pkg::byte_t vin;
	adc_pkg::byte_t res;
	int             bad_count;
	int             tests_run;
	int             c;

	adc_serial_port_sequencer i_adc_serial_port_sequencer (.*);
	host_model                i_host_model (.*);

	initial clk = 1'b0;
	always #20 clk = ~clk;

	// stands in for the comparator against the held input vin
	always @(negedge clk)
		comp_hi <= (vin >= dac_code);

	task check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
	begin
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	end
	endtask : check

	task conclude;
	begin
		$display("checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask : conclude

	task run(input adc_pkg::byte_t cmd, input int zeros);
		logic [2:0] idx;
	begin
		idx = {cmd[5], cmd[4], cmd[6]};
		i_host_model.frame(cmd, zeros, res);
		repeat (6) @(negedge clk);
		check("result", vin, res);
		check("plus", 8'h01 << idx, pos_channel);
		check("return", cmd[2] ? 8'h00 : 8'h01 << (idx ^ 3'h1),
			neg_channel);
		check("common", cmd[2], neg_to_common);
		check("polarity", !cmd[3], bipolar_mode);
		check("power", cmd[1:0], power_mode);
		check("track", 3'h2, {i_host_model.track_at[9:8],
			i_host_model.track_at[6]});
		check("result oe", 1'b0, result_out_oe);
		if (cmd[1:0] == 2'h3)
		begin
			check("strobe", 4'h6, i_host_model.strobe_at[18:15]);
			check("strobe oe", 1'b0, conversion_strobe_oe);
		end
		else
			check("strobe", 2'h2, {conversion_strobe,
				i_host_model.strobe_at[0]});
		$display("test done, command %h", cmd);
	end
	endtask : run

	initial
	begin
		rst                   = 1'b1;
		power_down_sense_low  = 1'b0;
		power_down_sense_high = 1'b0;
		vin                   = 8'h00;
		bad_count             = 0;
		tests_run             = 0;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		repeat (8) i_host_model.pulse(1'b1);
		repeat (6) @(negedge clk);
		check("power", 2'h0, power_mode);
		i_host_model.abort_after(3);
		for (c = 0; c < 16; c++)
		begin
			vin = 8'(c * 17);
			run({1'b1, c[2:0], c[0] ^ c[3], c[3], 2'h3}, c % 3);
		end
		for (c = 0; c < 3; c++)
		begin
			vin = 8'(90 + c * 61);
			run({4'hD, 2'h2, 2'(c)}, 0);
		end
		power_down_sense_low = 1'b1;
		repeat (8) @(negedge clk);
		check("shutdown", 2'h2, {shutdown_all, shutdown_reference});
		power_down_sense_low  = 1'b0;
		power_down_sense_high = 1'b1;
		repeat (8) @(negedge clk);
		check("shutdown", 2'h1, {shutdown_all, shutdown_reference});
		power_down_sense_high = 1'b0;
		repeat (8) @(negedge clk);
		check("shutdown", 2'h0, {shutdown_all, shutdown_reference});
		$display("test done, power pin");
		conclude();
	end

	// tests need about 5k cycles; 50k cycles means a hang
	initial
	begin
		#2_000_000;
		bad_count++;
		conclude();
	end
endmodule : tb_top

`default_nettype wire
